// >>> design/dcas_interval.sv
`timescale 1ns/1ps
module dcas_interval
   import dcas_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Control
   input wire logic start_i,
   input wire logic [2:0] code_i,
   // Status
   output logic busy_o,
   output logic done_o
);
   logic [15:0] cnt_q;
   logic [15:0] len;

   always_comb begin
      unique case (code_i)
         3'h1: len = 16'(CYC_0P5MS);
         3'h2: len = 16'(CYC_1MS);
         3'h3: len = 16'(CYC_2MS);
         3'h4: len = 16'(CYC_4MS);
         3'h7: len = 16'(CYC_16US);
         default: len = 16'h0000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= 16'h0000;
         busy_o <= 1'b0;
         done_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (start_i) begin
            if (len == 16'h0000) begin
               done_o <= 1'b1;
               busy_o <= 1'b0;
            end else begin
               cnt_q <= len - 16'h0001;
               busy_o <= 1'b1;
            end
         end else if (busy_o) begin
            if (cnt_q == 16'h0000) begin
               busy_o <= 1'b0;
               done_o <= 1'b1;
            end else begin
               cnt_q <= cnt_q - 16'h0001;
            end
         end
      end
   end
endmodule

// >>> design/dcas_pkg.sv
package dcas_pkg;

   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] ACCEL_CAL_SETTINGS_OFF = 8'h00;
   localparam logic [7:0] CAL_STATUS_SELECTION_OFF = 8'h04;
   localparam logic [7:0] DIV_PROG_OFF = 8'h08;
   localparam logic [7:0] DIV_CTRL_OFF = 8'h0C;
   localparam logic [7:0] SEQ_STATUS_OFF = 8'h10;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int SETTLE_LSB = 0;
   localparam int FAST_LSB = 3;
   localparam int FRAC_SEL_LSB = 6;
   localparam int INT_SEL_BIT = 8;
   localparam int DIV_FRAC_LSB = 0;
   localparam int DIV_INT_LSB = 16;
   localparam int CTRL_RST_BIT = 0;
   localparam int CTRL_INTMODE_BIT = 1;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [8:0] ACCEL_RESET = 9'h148;
   localparam logic [1:0] STATUS_SEL_RESET = 2'h0;
   localparam logic [31:0] DIV_PROG_RESET = 32'h0064_0000;
   localparam logic [1:0] DIV_CTRL_RESET = 2'h0;

   // ----------------------------------------------------------------
   // Fixed divider values (fraction is 16-bit, 1.0 = 2^16)
   // ----------------------------------------------------------------
   localparam logic [15:0] FIXED_INT = 16'h0064;
   localparam logic [15:0] FIXED_FRAC_QUARTER = 16'h4000;
   localparam logic [15:0] FIXED_FRAC_HALF = 16'h8000;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 10_000_000;
   localparam int T_16US_US = 16;
   localparam int T_0P5MS_US = 500;
   localparam int T_1MS_US = 1000;
   localparam int T_2MS_US = 2000;
   localparam int T_4MS_US = 4000;
   localparam int CYC_16US = T_16US_US * (CLK_HZ / 1_000_000);
   localparam int CYC_0P5MS = T_0P5MS_US * (CLK_HZ / 1_000_000);
   localparam int CYC_1MS = T_1MS_US * (CLK_HZ / 1_000_000);
   localparam int CYC_2MS = T_2MS_US * (CLK_HZ / 1_000_000);
   localparam int CYC_4MS = T_4MS_US * (CLK_HZ / 1_000_000);
   localparam int RESYNC_CYC = 4;

   typedef enum logic [1:0] {
      DCAS_IDLE, DCAS_FAST, DCAS_SETTLE, DCAS_RESYNC
   } dcas_state_type;

endpackage

// >>> design/dcas_top.sv
`timescale 1ns/1ps
// Function
// - After fixed integer, resynchronise divider before outputs enable
// - Fraction select: 0 programmed, 1 quarter, 2 half
// - After fixed fraction, resynchronise divider before outputs enable
// - After reset release, fast-lock flag high for coded time
// - Then settle with fast-lock low for coded time, default off
// - Fraction select 1 or 2 holds fixed fraction through both intervals
// - Two-bit status select picks calibration status readback
// - Integer mode applies in idle after accelerated calibration ends, or while divider reset bit is set
module dcas_top
   import dcas_pkg::*;
(
   // Clock and reset
   input wire logic MCLK_I,
   input wire logic RST_I,
   // APB slave
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   // Divider control
   output logic [15:0] DIV_INT_O,
   output logic [15:0] DIV_FRAC_O,
   output logic FAST_LOCK_O,
   output logic DIV_RESYNC_O,
   output logic INT_MODE_O,
   output logic CLK_OUT_EN_O,
   output logic [1:0] STATUS_SEL_O
);
   import dcas_pkg::*;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [8:0] accel_q;
   logic [1:0] ssel_q;
   logic [31:0] prog_q;
   logic [1:0] ctrl_q;
   logic startup_q;
   logic rst_bit_d1_q;
   logic used_fixed_q;
   logic [2:0] rs_cnt_q;
   dcas_state_type state_q;
   logic fast_busy, fast_done, settle_busy, settle_done;
   logic start_fast, start_settle;
   logic wr, rd;
   logic [31:0] rdata;

   assign wr = PSEL_I & PENABLE_I & PWRITE_I;
   assign rd = PSEL_I & ~PENABLE_I & ~PWRITE_I;

   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         accel_q <= ACCEL_RESET;
         ssel_q <= STATUS_SEL_RESET;
         prog_q <= DIV_PROG_RESET;
         ctrl_q <= DIV_CTRL_RESET;
      end else if (wr) begin
         unique case (PADDR_I)
            ACCEL_CAL_SETTINGS_OFF: accel_q <= PWDATA_I[8:0];
            CAL_STATUS_SELECTION_OFF: ssel_q <= PWDATA_I[1:0];
            DIV_PROG_OFF: prog_q <= PWDATA_I;
            DIV_CTRL_OFF: ctrl_q <= PWDATA_I[1:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // APB read
   // ----------------------------------------------------------------
   always_comb begin
      rdata = 32'h0000_0000;
      unique case (PADDR_I)
         ACCEL_CAL_SETTINGS_OFF: rdata[8:0] = accel_q;
         CAL_STATUS_SELECTION_OFF: rdata[1:0] = ssel_q;
         DIV_PROG_OFF: rdata = prog_q;
         DIV_CTRL_OFF: rdata[1:0] = ctrl_q;
         SEQ_STATUS_OFF: rdata[2:0] = {CLK_OUT_EN_O, 2'(state_q)};
         default: ;
      endcase
   end

   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         PRDATA_O <= 32'h0000_0000;
         PREADY_O <= 1'b0;
         PSLVERR_O <= 1'b0;
      end else begin
         PREADY_O <= PSEL_I & ~PENABLE_I;
         PSLVERR_O <= PSEL_I & ~PENABLE_I &
            (PADDR_I > SEQ_STATUS_OFF || PADDR_I[1:0] != 2'h0);
         if (rd) begin
            PRDATA_O <= rdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // Interval timers
   // ----------------------------------------------------------------
   // startup or falling reset
   assign start_fast = (state_q == DCAS_IDLE) & ~ctrl_q[CTRL_RST_BIT] &
      (startup_q | rst_bit_d1_q);

   dcas_interval u_fast (
      .clk_i(MCLK_I),
      .rst_i(RST_I),
      .start_i(start_fast),
      .code_i(accel_q[FAST_LSB +: 3]),
      .busy_o(fast_busy),
      .done_o(fast_done)
   );

   assign start_settle = fast_done & (state_q == DCAS_FAST);

   dcas_interval u_settle (
      .clk_i(MCLK_I),
      .rst_i(RST_I),
      .start_i(start_settle),
      .code_i(accel_q[SETTLE_LSB +: 3]),
      .busy_o(settle_busy),
      .done_o(settle_done)
   );

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         state_q <= DCAS_IDLE;
         startup_q <= 1'b1;
         rst_bit_d1_q <= 1'b0;
         used_fixed_q <= 1'b0;
         rs_cnt_q <= 3'h0;
      end else begin
         rst_bit_d1_q <= ctrl_q[CTRL_RST_BIT];
         if (ctrl_q[CTRL_RST_BIT]) begin
            state_q <= DCAS_IDLE;
            startup_q <= 1'b0;
         end else begin
            unique case (state_q)
               DCAS_IDLE: begin
                  if (start_fast) begin
                     startup_q <= 1'b0;
                     state_q <= DCAS_FAST;
                     used_fixed_q <= accel_q[INT_SEL_BIT] |
                        (accel_q[FRAC_SEL_LSB +: 2] != 2'h0);
                  end
               end
               DCAS_FAST: begin
                  if (fast_done) begin
                     state_q <= DCAS_SETTLE;
                  end
               end
               DCAS_SETTLE: begin
                  if (settle_done) begin
                     if (used_fixed_q) begin
                        state_q <= DCAS_RESYNC;
                        rs_cnt_q <= 3'(RESYNC_CYC - 1);
                     end else begin
                        state_q <= DCAS_IDLE;
                     end
                  end
               end
               DCAS_RESYNC: begin
                  if (rs_cnt_q == 3'h0) begin
                     state_q <= DCAS_IDLE;
                  end else begin
                     rs_cnt_q <= rs_cnt_q - 3'h1;
                  end
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         DIV_INT_O <= 16'h0000;
         DIV_FRAC_O <= 16'h0000;
         FAST_LOCK_O <= 1'b0;
         DIV_RESYNC_O <= 1'b0;
         INT_MODE_O <= 1'b0;
         CLK_OUT_EN_O <= 1'b0;
         STATUS_SEL_O <= 2'h0;
      end else begin
         STATUS_SEL_O <= ssel_q;
         FAST_LOCK_O <= fast_busy & (state_q == DCAS_FAST);
         DIV_RESYNC_O <= (state_q == DCAS_RESYNC);
         INT_MODE_O <= ctrl_q[CTRL_INTMODE_BIT] & (state_q == DCAS_IDLE) &
            ~start_fast;
         CLK_OUT_EN_O <= (state_q == DCAS_IDLE) & ~start_fast &
            ~ctrl_q[CTRL_RST_BIT] & ~startup_q;
         DIV_INT_O <= prog_q[DIV_INT_LSB +: 16];
         DIV_FRAC_O <= prog_q[DIV_FRAC_LSB +: 16];
         if ((state_q == DCAS_FAST || state_q == DCAS_SETTLE) &&
            (fast_busy || settle_busy || start_settle)) begin
            if (accel_q[INT_SEL_BIT]) begin
               DIV_INT_O <= FIXED_INT;
            end
            unique case (accel_q[FRAC_SEL_LSB +: 2])
               2'h1: DIV_FRAC_O <= FIXED_FRAC_QUARTER;
               2'h2: DIV_FRAC_O <= FIXED_FRAC_HALF;
               default: ;
            endcase
         end
      end
   end
endmodule

// >>> dv/dcas_monitor.sv
`timescale 1ns/1ps
module dcas_monitor (
   // Clock and reset
   input wire logic MCLK_I,
   input wire logic RST_I,
   // Bus
   input wire logic PREADY_O,
   // Divider control
   input wire logic [15:0] DIV_INT_O,
   input wire logic [15:0] DIV_FRAC_O,
   input wire logic FAST_LOCK_O,
   input wire logic DIV_RESYNC_O,
   input wire logic INT_MODE_O,
   input wire logic CLK_OUT_EN_O
);
   // ------------------------------------------------------------
   // Sequencing checks
   // ------------------------------------------------------------
   default clocking dc @(posedge MCLK_I);
   endclocking
   default disable iff (RST_I);
   chk_out_no_fast: assert property (
      CLK_OUT_EN_O |-> !FAST_LOCK_O) else $error("outputs on in fast");
   chk_resync_first: assert property (
      $rose(CLK_OUT_EN_O) |-> !DIV_RESYNC_O && $past(!CLK_OUT_EN_O))
      else $error("outputs on during resync");
   chk_resync_len: assert property (
      $rose(DIV_RESYNC_O) |-> DIV_RESYNC_O[*4] ##1 !DIV_RESYNC_O)
      else $error("resync length wrong");
   chk_int_mode_gate: assert property (
      INT_MODE_O |-> CLK_OUT_EN_O) else $error("integer mode early");
   chk_fast_hold: assert property (
      FAST_LOCK_O && $past(FAST_LOCK_O) |-> $stable(DIV_FRAC_O)
      && $stable(DIV_INT_O)) else $error("divider moved in fast");
   chk_resync_quiet: assert property (
      DIV_RESYNC_O |-> !FAST_LOCK_O && !CLK_OUT_EN_O)
      else $error("resync overlaps");
   chk_fast_then_off: assert property (
      $fell(FAST_LOCK_O) |-> !CLK_OUT_EN_O) else $error("no settle gap");
   chk_ready_pulse: assert property (
      PREADY_O |=> !PREADY_O) else $error("ready too long");
endmodule
bind dcas_top dcas_monitor dcas_monitor_inst (.MCLK_I(MCLK_I),
   .RST_I(RST_I), .PREADY_O(PREADY_O), .DIV_INT_O(DIV_INT_O),
   .DIV_FRAC_O(DIV_FRAC_O), .FAST_LOCK_O(FAST_LOCK_O),
   .DIV_RESYNC_O(DIV_RESYNC_O), .INT_MODE_O(INT_MODE_O),
   .CLK_OUT_EN_O(CLK_OUT_EN_O));

// >>> dv/dcas_tb_top.sv
`timescale 1ns/1ps
module dcas_tb_top;
   import dcas_pkg::*;
   logic MCLK_I, RST_I, PSEL_I, PENABLE_I, PWRITE_I, PREADY_O, PSLVERR_O;
   logic FAST_LOCK_O, DIV_RESYNC_O, INT_MODE_O, CLK_OUT_EN_O, er;
   logic [7:0] PADDR_I;
   logic [31:0] PWDATA_I, PRDATA_O, rd;
   logic [15:0] DIV_INT_O, DIV_FRAC_O;
   logic [1:0] STATUS_SEL_O;
   int mismatches = 0;
   int total_checks = 0;
   dcas_top dcas_top_inst (.MCLK_I(MCLK_I), .RST_I(RST_I),
      .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
      .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
      .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .DIV_INT_O(DIV_INT_O),
      .DIV_FRAC_O(DIV_FRAC_O), .FAST_LOCK_O(FAST_LOCK_O),
      .DIV_RESYNC_O(DIV_RESYNC_O), .INT_MODE_O(INT_MODE_O),
      .CLK_OUT_EN_O(CLK_OUT_EN_O), .STATUS_SEL_O(STATUS_SEL_O));
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      PSEL_I <= 1'b1;
      PWRITE_I <= w;
      PADDR_I <= a;
      PWDATA_I <= d;
      @(posedge MCLK_I);
      PENABLE_I <= 1'b1;
      n = 0;
      do begin
         @(posedge MCLK_I);
         n++;
      end while (PREADY_O !== 1'b1 && n < 100);
      if (n >= 100) begin
         mismatches++;
         results();
      end
      rd = PRDATA_O;
      er = PSLVERR_O;
      PSEL_I <= 1'b0;
      PENABLE_I <= 1'b0;
      @(posedge MCLK_I);
   endtask
   task automatic run(input int ef, input int ers, input logic [15:0] ei,
                      input logic [15:0] efr);
      int n, nf, nr;
      logic [15:0] fi, ff;
      n = 0;
      nf = 0;
      nr = 0;
      while (CLK_OUT_EN_O !== 1'b1 && n < 50000) begin
         @(negedge MCLK_I);
         n++;
         if (CLK_OUT_EN_O !== 1'b1) chk(INT_MODE_O, 0);
         if (FAST_LOCK_O === 1'b1 && nf == 0) begin
            fi = DIV_INT_O;
            ff = DIV_FRAC_O;
         end
         if (FAST_LOCK_O === 1'b1) nf++;
         if (DIV_RESYNC_O === 1'b1) nr++;
      end
      if (n >= 50000) begin
         mismatches++;
         results();
      end
      chk(nf, ef);
      chk(nr, ers);
      if (ef > 0) begin
         chk(fi, ei);
         chk(ff, efr);
      end
      @(posedge MCLK_I);
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_startup;
      run(CYC_0P5MS, RESYNC_CYC, FIXED_INT, FIXED_FRAC_QUARTER);
      chk(DIV_INT_O, DIV_PROG_RESET[31:16]);
      chk(DIV_FRAC_O, 0);
   endtask
   task automatic t_regs;
      apb(0, ACCEL_CAL_SETTINGS_OFF, 0);
      chk(rd, 32'h0000_0148);
      apb(1, CAL_STATUS_SELECTION_OFF, 32'hFFFF_FFFF);
      @(negedge MCLK_I);
      chk(STATUS_SEL_O, 2'h3);
      @(posedge MCLK_I);
      apb(0, CAL_STATUS_SELECTION_OFF, 0);
      chk(rd, 32'h0000_0003);
      apb(0, 8'h14, 0);
      chk({31'h0, er}, 32'h0000_0001);
      chk(rd, 32'h0000_0000);
   endtask
   task automatic t_fixed;
      apb(1, DIV_PROG_OFF, 32'h0020_1234);
      apb(1, ACCEL_CAL_SETTINGS_OFF, 32'h0000_00BF);
      apb(1, DIV_CTRL_OFF, 32'h0000_0001);
      apb(1, DIV_CTRL_OFF, 32'h0000_0002);
      run(CYC_16US, RESYNC_CYC, 16'h0020, FIXED_FRAC_HALF);
      chk({DIV_INT_O, DIV_FRAC_O}, 32'h0020_1234);
      repeat (2) @(posedge MCLK_I);
      chk(INT_MODE_O, 1);
   endtask
   task automatic t_codes;
      apb(1, ACCEL_CAL_SETTINGS_OFF, 32'hFFFF_FE2E);
      apb(0, ACCEL_CAL_SETTINGS_OFF, 0);
      chk(rd, 32'h0000_002E);
      apb(1, DIV_CTRL_OFF, 32'h0000_0001);
      apb(1, DIV_CTRL_OFF, 32'h0000_0000);
      run(0, 0, 0, 0);
   endtask
   task automatic t_abort;
      apb(1, ACCEL_CAL_SETTINGS_OFF, 32'h0000_0038);
      apb(1, DIV_CTRL_OFF, 32'h0000_0001);
      apb(1, DIV_CTRL_OFF, 32'h0000_0000);
      apb(1, DIV_CTRL_OFF, 32'h0000_0001);
      repeat (2) @(posedge MCLK_I);
      chk({FAST_LOCK_O, CLK_OUT_EN_O}, 2'h0);
      apb(1, DIV_CTRL_OFF, 32'h0000_0000);
      run(CYC_16US, 0, 16'h0020, 16'h1234);
   endtask
   initial begin
      MCLK_I = 1'b0;
      forever #50 MCLK_I = ~MCLK_I;
   end
   initial begin
      {PSEL_I, PENABLE_I, PWRITE_I, PADDR_I, PWDATA_I} = '0;
      RST_I = 1'b1;
      repeat (2) @(posedge MCLK_I);
      RST_I <= 1'b0;
      t_startup();
      t_regs();
      t_fixed();
      t_codes();
      t_abort();
      results();
   end
endmodule
